// file: rtl/tone_freq_pkg.sv
package tone_freq_pkg;

    // Command codes on the serial command bus
    localparam logic [7:0] CMD_GENERAL_RESET  = 8'h01;
    localparam logic [7:0] CMD_WRITE_CONTROL  = 8'h30;
    localparam logic [7:0] CMD_READ_STATUS    = 8'h31;
    localparam logic [7:0] CMD_READ_FREQUENCY = 8'h32;
    localparam logic [7:0] CMD_WRITE_TONE_TWO = 8'h35;

    // Register offsets are the command codes that reach them
    localparam logic [7:0] RX_FREQUENCY_RESULT_OFFSET = CMD_READ_FREQUENCY;
    localparam logic [7:0] TONE_TWO_CONTROL_OFFSET    = CMD_WRITE_TONE_TWO;

    // Second generator word layout
    localparam int DIVISOR_W        = 13;
    localparam int SILENCE_BIT      = 13;
    localparam int SQUARE_BIT       = 14;
    localparam logic [15:0] TONE_TWO_RESET = 16'h0000;

    // Control and status layout
    localparam int BAND_LSB         = 2;
    localparam int BAND_MSB         = 3;
    localparam int DECODER_IRQ_BIT  = 5;
    localparam int MEASURE_DONE_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] REPLY_PAD     = 8'h00;

    // Serial framing
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    typedef enum logic [1:0] {
        BAND_HIGH     = 2'h0,
        BAND_MID      = 2'h1,
        BAND_EXTENDED = 2'h2,
        BAND_UNUSED   = 2'h3
    } band_t;

    typedef enum logic [1:0] {
        AUX_GROUND = 2'h0,
        AUX_BIAS   = 2'h1,
        AUX_TONE   = 2'h2
    } aux_level_t;

    // Timing, all derived from the crystal
    localparam real CLOCK_MHZ      = 200.0;
    localparam real XTAL_MHZ       = 4.032;
    localparam real WINDOW_WIDE_MS = 9.125;
    localparam real WINDOW_MID_MS  = 18.250;
    localparam real MCLK_WIDE_KHZ  = 56.00;
    localparam real MCLK_MID_KHZ   = 28.00;
    localparam int  XTAL_CLOCKS    = $rtoi(CLOCK_MHZ / XTAL_MHZ);
    localparam int  MCLK_WIDE_XTAL = int'(XTAL_MHZ * 1000.0 / MCLK_WIDE_KHZ);
    localparam int  MCLK_MID_XTAL  = int'(XTAL_MHZ * 1000.0 / MCLK_MID_KHZ);
    localparam int  WINDOW_MCLKS   = int'(WINDOW_WIDE_MS * MCLK_WIDE_KHZ);
    localparam int  TONE_QUARTERS  = 4;
    localparam int  MIN_HALF_PERIODS = 2;
    localparam int  BYTE_MAX       = 255;

endpackage

// file: rtl/tone_two_generator.sv
`timescale 1ns/1ps
`default_nettype none
module tone_two_generator (
    input  wire logic                               clock,
    input  wire logic                               rst,
    input  wire logic                               xtal_tick,
    input  wire logic [tone_freq_pkg::DIVISOR_W-1:0] divisor,
    input  wire logic                               silence,
    input  wire logic                               square_select,
    output var  tone_freq_pkg::aux_level_t          aux_level,
    output logic                                    aux_square,
    output logic [1:0]                              aux_quarter,
    output logic                                    powersave
);
    import tone_freq_pkg::*;

    logic [DIVISOR_W-1:0] tick_count;
    logic [1:0]           quarter;
    wire                  is_off   = (divisor == '0);
    wire                  at_wrap  = xtal_tick && (tick_count == divisor - 1'b1);

    // Quarter steps of B crystal ticks give one period of 4 x B ticks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_count <= '0;
            quarter    <= 2'h0;
        end else if (is_off) begin
            tick_count <= '0;
            quarter    <= 2'h0;
        end else if (at_wrap) begin
            tick_count <= '0;
            quarter    <= quarter + 2'h1;
        end else if (xtal_tick) begin
            tick_count <= tick_count + 1'b1;
        end
    end

    // Output level: ground in power-save, bias when silenced
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aux_level   <= AUX_GROUND;
            aux_square  <= 1'b0;
            aux_quarter <= 2'h0;
            powersave   <= 1'b1;
        end else begin
            powersave   <= is_off;
            aux_level   <= is_off ? AUX_GROUND : (silence ? AUX_BIAS : AUX_TONE);
            aux_square  <= square_select;
            aux_quarter <= quarter;
        end
    end
endmodule
`default_nettype wire

// file: rtl/rx_frequency_counter.sv
`timescale 1ns/1ps
`default_nettype none
module rx_frequency_counter (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  xtal_tick,
    input  wire tone_freq_pkg::band_t  band,
    input  wire logic                  rx_tone,
    output logic                       done,
    output logic [7:0]                 half_periods,
    output logic [7:0]                 remainder
);
    import tone_freq_pkg::*;

    typedef enum logic {WAIT_EDGE = 1'b0, MEASURE = 1'b1} count_state_t;

    count_state_t state;
    logic         rx_prev;
    logic         mid_band;
    logic [7:0]   xtal_count;
    logic [8:0]   mclk_count;
    logic [8:0]   edge_count;
    logic [8:0]   last_edge_mclk;

    wire       rx_edge    = rx_tone ^ rx_prev;
    wire [7:0] mclk_last  = mid_band ? 8'(MCLK_MID_XTAL - 1) : 8'(MCLK_WIDE_XTAL - 1);
    wire       mclk_tick  = xtal_tick && (xtal_count == mclk_last);
    wire       win_end    = (state == MEASURE) && mclk_tick && (mclk_count == 9'(WINDOW_MCLKS - 1));
    wire [8:0] rest       = 9'(WINDOW_MCLKS) - last_edge_mclk;
    wire       good       = (edge_count >= 9'(MIN_HALF_PERIODS)) && (edge_count <= 9'(BYTE_MAX))
                            && (rest <= 9'(BYTE_MAX));

    // Window starts on an input edge; 511 measuring ticks in every band
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state          <= WAIT_EDGE;
            rx_prev        <= 1'b0;
            mid_band       <= 1'b0;
            xtal_count     <= 8'h00;
            mclk_count     <= 9'h000;
            edge_count     <= 9'h000;
            last_edge_mclk <= 9'h000;
        end else begin
            rx_prev <= rx_tone;
            case (state)
                WAIT_EDGE: begin
                    if (rx_edge) begin
                        state          <= MEASURE;
                        mid_band       <= (band == BAND_MID);
                        xtal_count     <= 8'h00;
                        mclk_count     <= 9'h000;
                        edge_count     <= 9'h000;
                        last_edge_mclk <= 9'h000;
                    end
                end
                MEASURE: begin
                    if (xtal_tick) begin
                        xtal_count <= mclk_tick ? 8'h00 : xtal_count + 8'h01;
                    end
                    if (mclk_tick) begin
                        mclk_count <= mclk_count + 9'h001;
                    end
                    // Half cycles first, then measuring ticks to fill the window
                    if (rx_edge && !win_end && edge_count != 9'h1FF) begin
                        edge_count     <= edge_count + 9'h001;
                        last_edge_mclk <= mclk_tick ? mclk_count + 9'h001 : mclk_count;
                    end
                    if (win_end) begin
                        state <= WAIT_EDGE;
                    end
                end
                default: state <= WAIT_EDGE;
            endcase
        end
    end

    // Result only on a successful window
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done         <= 1'b0;
            half_periods <= 8'h00;
            remainder    <= 8'h00;
        end else begin
            done <= win_end && good;
            if (win_end && good) begin
                half_periods <= edge_count[7:0];
                remainder    <= rest[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/tone_gen_and_freq_counter.sv
// Behaviour
// - Command 35h plus two bytes, MSB first, loads the 16-bit generator word.
// - Bits 0..12 are the divisor; zero puts generator two in power-save.
// - Bit 13 set holds tone output at bias; clear enables it.
// - Bit 14 selects auxiliary waveform: one square, zero sine.
// - Silenced output parks at bias; power-save drives it to ground.
// - Both generators in power-save also power-saves the input amplifier.
// - Tone frequency is crystal frequency over four times the divisor.
// - Command 32h returns count byte then remainder byte.
// - Window is 9.125 ms high/extended, 18.250 ms mid band.
// - Count input half cycles first, then measuring ticks to end of window.
// - Count byte holds the number of input half periods.
// - Remainder counts 56 kHz or 28 kHz ticks filling the window.
// - Successful window sets completion status, interrupt, and result register.
// - Window and measuring clock scale with the crystal frequency.
// - Control bits 3..2 select band: high, mid, extended; 11 unused.
// - Status bit 0 flags completion; cleared by status read or general reset.
`timescale 1ns/1ps
`default_nettype none
module tone_gen_and_freq_counter #(
    parameter int XTAL_CLOCKS = tone_freq_pkg::XTAL_CLOCKS
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      serial_clock,
    input  wire logic                      bus_select_n,
    input  wire logic                      command_data,
    input  wire logic                      rx_tone,
    input  wire logic                      tone_one_powersave,
    output logic                           reply_data,
    output logic                           irq_n,
    output var  tone_freq_pkg::aux_level_t aux_tone_output,
    output logic                           aux_tone_square,
    output logic [1:0]                     aux_tone_quarter,
    output logic                           tone_two_powersave,
    output logic                           input_amp_powersave
);
    import tone_freq_pkg::*;

    typedef enum logic [1:0] {
        BUS_COMMAND = 2'b00,
        BUS_DATA    = 2'b01,
        BUS_REPLY   = 2'b11,
        BUS_IGNORE  = 2'b10
    } bus_state_t;

    bus_state_t  bus_state;
    logic        serial_prev;
    logic [2:0]  bit_index;
    logic [6:0]  shift_in;
    logic [7:0]  command;
    logic [7:0]  data_high;
    logic        have_high;
    logic [15:0] reply_shift;
    logic [7:0]  control;
    logic [15:0] tone_two_control;
    logic [15:0] rx_frequency_result;
    logic        measure_complete;
    logic [15:0] xtal_count;
    logic        xtal_tick;

    logic        measure_done;
    logic [7:0]  measured_count;
    logic [7:0]  measured_remainder;

    // Serial clock edges, sampled in the system clock domain
    wire       selected     = !bus_select_n;
    wire       serial_rise  = selected && serial_clock && !serial_prev;
    wire       serial_fall  = selected && !serial_clock && serial_prev;
    wire [7:0] next_byte    = {shift_in, command_data};
    wire       byte_done    = serial_rise && (bit_index == LAST_BIT_INDEX);

    // Command decode
    wire take_command  = byte_done && (bus_state == BUS_COMMAND);
    wire take_data     = byte_done && (bus_state == BUS_DATA);
    wire general_reset = take_command && (next_byte == CMD_GENERAL_RESET);
    wire read_status   = take_command && (next_byte == CMD_READ_STATUS);
    wire read_freq     = take_command && (next_byte == RX_FREQUENCY_RESULT_OFFSET);
    wire data_command  = (next_byte == CMD_WRITE_CONTROL) || (next_byte == TONE_TWO_CONTROL_OFFSET);
    wire write_control = take_data && (command == CMD_WRITE_CONTROL);
    wire tone_byte     = take_data && (command == TONE_TWO_CONTROL_OFFSET);
    wire write_tone    = tone_byte && have_high;
    wire [7:0] status_byte = {7'h00, measure_complete};

    // Crystal tick divider, the time base of both generator and counter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            xtal_count <= 16'h0000;
            xtal_tick  <= 1'b0;
        end else begin
            xtal_tick  <= (xtal_count == 16'(XTAL_CLOCKS - 1));
            xtal_count <= (xtal_count == 16'(XTAL_CLOCKS - 1)) ? 16'h0000 : xtal_count + 16'h0001;
        end
    end

    // Bit counter and input shifter; deselect restarts framing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_prev <= 1'b0;
            bit_index   <= 3'h0;
            shift_in    <= 7'h00;
        end else begin
            serial_prev <= serial_clock;
            if (!selected) begin
                bit_index <= 3'h0;
            end else if (serial_rise) begin
                bit_index <= bit_index + 3'h1;
                shift_in  <= next_byte[6:0];
            end
        end
    end

    // Transaction state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_state <= BUS_COMMAND;
            command   <= 8'h00;
            have_high <= 1'b0;
            data_high <= 8'h00;
        end else if (!selected) begin
            bus_state <= BUS_COMMAND;
            have_high <= 1'b0;
        end else if (take_command) begin
            command   <= next_byte;
            have_high <= 1'b0;
            if (data_command) begin
                bus_state <= BUS_DATA;
            end else if (read_status || read_freq) begin
                bus_state <= BUS_REPLY;
            end else begin
                bus_state <= BUS_IGNORE;
            end
        end else if (tone_byte && !have_high) begin
            data_high <= next_byte;
            have_high <= 1'b1;
        end else if (take_data) begin
            bus_state <= BUS_IGNORE;
        end
    end

    // Reply shifter: loaded on the command byte, shifted on falling edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reply_shift <= 16'h0000;
            reply_data  <= 1'b0;
        end else if (read_status) begin
            reply_shift <= {status_byte, REPLY_PAD};
        end else if (read_freq) begin
            reply_shift <= rx_frequency_result;
        end else if (serial_fall && bus_state == BUS_REPLY) begin
            reply_data  <= reply_shift[15];
            reply_shift <= {reply_shift[14:0], 1'b0};
        end
    end

    // Writable registers; general reset returns them to defaults
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control          <= CONTROL_RESET;
            tone_two_control <= TONE_TWO_RESET;
        end else if (general_reset) begin
            control          <= CONTROL_RESET;
            tone_two_control <= TONE_TWO_RESET;
        end else if (write_control) begin
            control          <= next_byte;
        end else if (write_tone) begin
            tone_two_control <= {data_high, next_byte};
        end
    end

    // Completion flag: a new completion wins over a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            measure_complete    <= 1'b0;
            rx_frequency_result <= 16'h0000;
        end else begin
            measure_complete <= measure_done || (measure_complete && !(read_status || general_reset));
            if (measure_done) begin
                rx_frequency_result <= {measured_count, measured_remainder};
            end
        end
    end

    // Registered interrupt and amplifier power-save
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_n               <= 1'b1;
            input_amp_powersave <= 1'b0;
        end else begin
            irq_n               <= !(measure_complete && control[DECODER_IRQ_BIT]);
            input_amp_powersave <= tone_one_powersave && tone_two_powersave;
        end
    end

    // Second tone generator
    tone_two_generator u_tone_two (
        .clock         (clock),
        .rst           (rst),
        .xtal_tick     (xtal_tick),
        .divisor       (tone_two_control[DIVISOR_W-1:0]),
        .silence       (tone_two_control[SILENCE_BIT]),
        .square_select (tone_two_control[SQUARE_BIT]),
        .aux_level     (aux_tone_output),
        .aux_square    (aux_tone_square),
        .aux_quarter   (aux_tone_quarter),
        .powersave     (tone_two_powersave)
    );

    // Receive frequency counter
    rx_frequency_counter u_counter (
        .clock        (clock),
        .rst          (rst),
        .xtal_tick    (xtal_tick),
        .band         (band_t'(control[BAND_MSB:BAND_LSB])),
        .rx_tone      (rx_tone),
        .done         (measure_done),
        .half_periods (measured_count),
        .remainder    (measured_remainder)
    );
endmodule
`default_nettype wire

// file: tb/tone_freq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tone_freq_checker #(
    parameter int XTAL_CLOCKS = 1
) (
    input wire logic                      clock,
    input wire logic                      rst,
    input wire logic                      serial_clock,
    input wire logic                      bus_select_n,
    input wire logic                      command_data,
    input wire logic                      rx_tone,
    input wire logic                      tone_one_powersave,
    input wire logic                      reply_data,
    input wire logic                      irq_n,
    input wire tone_freq_pkg::aux_level_t aux_tone_output,
    input wire logic                      aux_tone_square,
    input wire logic [1:0]                aux_tone_quarter,
    input wire logic                      tone_two_powersave,
    input wire logic                      input_amp_powersave
);
    import tone_freq_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Outputs leave reset grounded and quiet
    property p_reset_state;
        $fell(rst) |-> irq_n && tone_two_powersave && !reply_data && aux_tone_output == AUX_GROUND;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("Outputs not in reset state");

    // Power-save grounds the auxiliary output
    property p_ground_in_ps;
        tone_two_powersave |-> aux_tone_output == AUX_GROUND;
    endproperty
    a_ground_in_ps: assert property (p_ground_in_ps) else $error("Aux output not grounded");

    // A running tone needs a nonzero divisor
    property p_tone_needs_divisor;
        aux_tone_output == AUX_TONE |-> !tone_two_powersave;
    endproperty
    a_tone_needs_divisor: assert property (p_tone_needs_divisor) else $error("Tone runs in power-save");

    // Amplifier sleeps only when both generators sleep
    property p_amp_both;
        (tone_one_powersave && tone_two_powersave) [*2] |=> input_amp_powersave;
    endproperty
    a_amp_both: assert property (p_amp_both) else $error("Amplifier not in power-save");

    property p_amp_one_off;
        (!tone_one_powersave || !tone_two_powersave) [*2] |=> !input_amp_powersave;
    endproperty
    a_amp_one_off: assert property (p_amp_one_off) else $error("Amplifier asleep too early");

    // Interrupt stays asserted while no status read can happen
    property p_irq_holds;
        !irq_n && bus_select_n |=> !irq_n;
    endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("Interrupt dropped without bus");

    // Reply bits move only after a serial clock fall
    property p_reply_on_fall;
        $changed(reply_data) && $past(!bus_select_n) |-> !$past(serial_clock);
    endproperty
    a_reply_on_fall: assert property (p_reply_on_fall) else $error("Reply changed off a falling edge");

    // Quarter index steps by one while the tone runs
    property p_quarter_step;
        $changed(aux_tone_quarter) && aux_tone_output == AUX_TONE && $past(aux_tone_output) == AUX_TONE
            |-> aux_tone_quarter == $past(aux_tone_quarter) + 2'h1;
    endproperty
    a_quarter_step: assert property (p_quarter_step) else $error("Quarter index skipped");

    property p_ps_quarter_still;
        tone_two_powersave [*3] |-> $stable(aux_tone_quarter);
    endproperty
    a_ps_quarter_still: assert property (p_ps_quarter_still) else $error("Generator runs in power-save");

    // Generator word changes only through a bus transfer
    property p_word_via_bus;
        $changed(aux_tone_square) || $changed(tone_two_powersave) |-> $past(!bus_select_n);
    endproperty
    a_word_via_bus: assert property (p_word_via_bus) else $error("Generator word changed off the bus");

    c_irq: cover property (!irq_n && bus_select_n);
    c_bias: cover property (aux_tone_output == AUX_BIAS);
    c_square: cover property (aux_tone_square && aux_tone_output == AUX_TONE);
endmodule

bind tone_gen_and_freq_counter tone_freq_checker #(.XTAL_CLOCKS(XTAL_CLOCKS)) tone_freq_checker_i (
    .clock(clock), .rst(rst), .serial_clock(serial_clock), .bus_select_n(bus_select_n),
    .command_data(command_data), .rx_tone(rx_tone), .tone_one_powersave(tone_one_powersave),
    .reply_data(reply_data), .irq_n(irq_n), .aux_tone_output(aux_tone_output),
    .aux_tone_square(aux_tone_square), .aux_tone_quarter(aux_tone_quarter),
    .tone_two_powersave(tone_two_powersave), .input_amp_powersave(input_amp_powersave)
);
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic clock,
    input  wire logic reply_data,
    output logic      serial_clock,
    output logic      bus_select_n,
    output logic      command_data
);
    // Idle bus: deselected, serial clock still
    initial begin
        serial_clock = 1'b0;
        bus_select_n = 1'b1;
        command_data = 1'b1;
    end

    // One bit: low phase then high phase, two clocks each
    task automatic bit_cycle(input logic b, output logic r);
        @(negedge clock);
        serial_clock = 1'b0;
        command_data = b;
        repeat (2) @(negedge clock);
        r = reply_data;
        serial_clock = 1'b1;
        repeat (2) @(negedge clock);
    endtask

    // Framed transfer: command byte, then data bytes out while reply bits come in
    task automatic transfer(input logic [7:0] cmd, input logic [15:0] data, input int nbytes,
                            output logic [15:0] reply);
        logic r;
        reply = 16'h0000;
        @(negedge clock);
        bus_select_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(cmd[i], r);
        end
        for (int i = 15; i >= 16 - 8 * nbytes; i--) begin
            bit_cycle(data[i], r);
            reply = {reply[14:0], r};
        end
        @(negedge clock);
        bus_select_n = 1'b1;
        serial_clock = 1'b0;
        command_data = ~command_data;
        repeat (2) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tone_freq_pkg::*;
    localparam int XC    = 1;
    localparam int TICK  = MCLK_WIDE_XTAL * XC;
    localparam int HALF  = 200;
    localparam int N_EXP = (511 * TICK - 1) / HALF;
    localparam int R_EXP = 511 - (N_EXP * HALF) / TICK;
    logic        clock;
    logic        rst;
    logic        rx_tone;
    logic        tone_one_powersave;
    logic        serial_clock;
    logic        bus_select_n;
    logic        command_data;
    logic        reply_data;
    logic        irq_n;
    aux_level_t  aux_tone_output;
    logic        aux_tone_square;
    logic [1:0]  aux_tone_quarter;
    logic        tone_two_powersave;
    logic        input_amp_powersave;
    logic [15:0] rep;
    int          error_cnt;
    int          num_checks;

    tone_gen_and_freq_counter #(.XTAL_CLOCKS(XC)) tone_gen_and_freq_counter_i (
        .clock(clock), .rst(rst), .serial_clock(serial_clock), .bus_select_n(bus_select_n),
        .command_data(command_data), .rx_tone(rx_tone), .tone_one_powersave(tone_one_powersave),
        .reply_data(reply_data), .irq_n(irq_n), .aux_tone_output(aux_tone_output),
        .aux_tone_square(aux_tone_square), .aux_tone_quarter(aux_tone_quarter),
        .tone_two_powersave(tone_two_powersave), .input_amp_powersave(input_amp_powersave)
    );
    host_model host_model_i (
        .clock(clock), .reply_data(reply_data), .serial_clock(serial_clock),
        .bus_select_n(bus_select_n), .command_data(command_data)
    );

    // Clock generator
    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] cmd, input logic [15:0] word, input int nbytes);
        host_model_i.transfer(cmd, word, nbytes, rep);
    endtask

    // Clocks until the quarter index moves, bounded
    task automatic quarter_gap(output int n);
        logic [1:0] q;
        q = aux_tone_quarter;
        n = 0;
        while (aux_tone_quarter === q && n < 20000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 20000) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic sc_reset();
        check(tone_two_powersave, 1'b1);
        check(aux_tone_output, AUX_GROUND);
        check(irq_n, 1'b1);
        check(input_amp_powersave, 1'b0);
    endtask

    // Short divisors run fast; out-of-band tones are accepted
    task automatic sc_tone();
        logic [15:0] words [3];
        int n;
        words = '{16'h4003, 16'h0007, 16'h1000};
        foreach (words[i]) begin
            send(CMD_WRITE_TONE_TWO, words[i], 2);
            check(aux_tone_output, AUX_TONE);
            check(aux_tone_square, words[i][14]);
            check(tone_two_powersave, 1'b0);
            quarter_gap(n);
            quarter_gap(n);
            check(16'(n), 16'(words[i][12:0] * XC));
        end
    endtask

    task automatic sc_quiet();
        tone_one_powersave = 1'b1;
        send(CMD_WRITE_TONE_TWO, 16'h2005, 2);
        check(aux_tone_output, AUX_BIAS);
        check(input_amp_powersave, 1'b0);
        send(CMD_WRITE_TONE_TWO, 16'h2000, 2);
        check(aux_tone_output, AUX_GROUND);
        check(input_amp_powersave, 1'b1);
        tone_one_powersave = 1'b0;
        repeat (2) @(negedge clock);
        check(input_amp_powersave, 1'b0);
    endtask

    // High band window with a steady input, then readout and status clear
    task automatic sc_measure();
        send(CMD_WRITE_CONTROL, 16'h2000, 1);
        rx_tone = ~rx_tone;
        for (int k = 1; k <= N_EXP + 2; k++) begin
            repeat (HALF) @(negedge clock);
            rx_tone = ~rx_tone;
            if (k == N_EXP) begin
                check(irq_n, 1'b1);
            end
        end
        check(irq_n, 1'b0);
        send(CMD_READ_FREQUENCY, 16'h0000, 2);
        check(rep, 16'(N_EXP * 256 + R_EXP));
        check(16'(rep[15:8] * HALF - (511 - rep[7:0]) * TICK < TICK), 16'h0001);
        send(CMD_READ_STATUS, 16'h0000, 2);
        check(rep[15:8], 8'h01);
        check(irq_n, 1'b1);
        send(CMD_READ_STATUS, 16'h0000, 2);
        check(rep[15:8], 8'h00);
    endtask

    task automatic sc_general_reset();
        send(CMD_WRITE_TONE_TWO, 16'h4003, 2);
        check(aux_tone_square, 1'b1);
        send(CMD_GENERAL_RESET, 16'h0000, 0);
        check(tone_two_powersave, 1'b1);
        check(aux_tone_square, 1'b0);
        check(aux_tone_output, AUX_GROUND);
    endtask

    // Hang guard
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        rx_tone = 1'b0;
        tone_one_powersave = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        sc_reset();
        sc_tone();
        sc_quiet();
        sc_measure();
        sc_general_reset();
        summarize();
    end
endmodule
`default_nettype wire
